// File: rtl/dmem_pkg.sv
// Constants and carrier types for the data memory and register page decoder.
package dmem_pkg;
	localparam int          RAM_BYTES      = 256;
	localparam logic [7:0]  LOWER_TOP      = 8'h7F;
	localparam logic [7:0]  BIT_AREA_BASE  = 8'h20;
	localparam logic [7:0]  ADDR_STACK_TOP = 8'h81;
	localparam logic [7:0]  ADDR_PAGE_CTRL = 8'h81;
	localparam logic [7:0]  ADDR_PAGE_CUR  = 8'h84;
	localparam logic [7:0]  ADDR_PAGE_NEXT = 8'h85;
	localparam logic [7:0]  ADDR_PAGE_LAST = 8'h86;
	localparam logic [7:0]  ADDR_STATUS    = 8'hD0;
	localparam logic [7:0]  PAGE_CTRL_PAGE = 8'h0F;
	localparam logic [7:0]  STACK_TOP_RST  = 8'h07;
	localparam logic [7:0]  PAGE_RST       = 8'h00;
	localparam logic [7:0]  PAGE_EMPTY     = 8'h00;
	localparam logic [7:0]  STATUS_RST     = 8'h00;
	localparam logic        AUTO_PAGE_RST  = 1'b1;
	localparam int          AUTO_PAGE_BIT  = 0;
	localparam int          BANK_LO_BIT    = 3;
	localparam int          BANK_HI_BIT    = 4;
	localparam int          RECORD_BITS    = 32;

	// Stack operations requested by the sequencer.
	typedef enum logic [2:0] {
		STK_NONE, STK_PUSH, STK_POP, STK_CALL, STK_RET, STK_INC, STK_DEC
	} stackOp_t;

	// One data memory access from the sequencer.
	typedef struct packed {
		logic       valid;
		logic       write;
		logic       indirect;
		logic       bitOp;
		logic       regSel;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       bitVal;
	} accReq_t;

	// One stack request: operation plus the value that a push or call stores.
	typedef struct packed {
		stackOp_t    op;
		logic [15:0] data;
	} stackReq_t;

	// Request to the peripheral register space outside this block.
	typedef struct packed {
		logic       req;
		logic       write;
		logic [7:0] addr;
		logic [7:0] page;
		logic [7:0] wdata;
		logic [7:0] bitMask;
	} sfrBus_t;
endpackage : dmem_pkg

// File: rtl/data_memory_sfr_paging.sv
// Internal data memory, register page selection and stack record logic.
// Functional notes
// - 256 bytes of internal RAM at addresses 0x00 to 0xFF.
// - Lower 128 bytes reached identically by direct and indirect access.
// - Above 0x7F, direct goes to register space, indirect to upper RAM.
// - 0x00-0x1F are four banks of eight; status word bits 3,4 pick one.
// - Indirect address comes from bank register zero or one of active bank.
// - Bytes 0x20-0x2F bit addressable; bit address (byte-0x20)*8+position.
// - Bit operand means single-bit access, byte operand whole-byte access.
// - Stack pointer marks last used byte; push writes pointer+1 then increments.
// - Reset loads stack pointer with 0x07.
// - Stack may sit anywhere in the 256 bytes, up to 256 deep.
// - 32-bit record: in one per push/increment, two per call; out likewise.
// - Record overflow and underflow are flagged to debug at full speed.
// - Register addresses ending 0x0 or 0x8 are bit addressable, others byte only.
// - 8-bit page select, 256 pages; pages 0,1,2,3 and F exist.
// - Interrupt entry pushes current into second, second into third, loads source page.
// - Interrupt return pops second into current, third into second, 0x00 fills.
// - Software writes to second and third entries overwrite without push or pop.
// - Page stack moves only on interrupt entry and return.
// - Automatic paging enable bit is set after reset.
// - All-pages registers decode the same whatever page is selected.
// - Enable is bit 0 at 0x81 in page 0x0F; clearing stops auto load and stack moves.
// - Reading the second entry gives the page restored on next return.
`timescale 1ns/100ps
`default_nettype none
module data_memory_sfr_paging
	import dmem_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire dmem_pkg::accReq_t acc,
	input  wire dmem_pkg::stackReq_t stk,
	input  wire logic              intEntry,
	input  wire logic [7:0]        intPage,
	input  wire logic              intReturn,
	input  wire logic [7:0]        sfrRdData,
	input  wire logic              recordClear,
	output dmem_pkg::sfrBus_t      sfrOut,
	output logic [7:0]             rdData,
	output logic                   rdValid,
	output logic [15:0]            stkRdData,
	output logic                   stkRdValid,
	output logic                   recordOverflow,
	output logic                   recordUnderflow,
	output logic [7:0]             program_status_word
);
	import dmem_pkg::*;

	logic [7:0]  ram [RAM_BYTES];
	logic [7:0]  stack_top_pointer;
	logic [7:0]  current_page_select;
	logic [7:0]  page_stack_second;
	logic [7:0]  page_stack_bottom;
	logic        auto_page_enable;
	logic [RECORD_BITS-1:0] record;
	logic [5:0]  recordDepth;
	logic        extPending;
	logic        extBitOp;
	logic [2:0]  extBitPos;

	////////////////////////////////////////////////////////////////////////
	// Address decode.
	logic [4:0]  bankRegIdx;
	logic [7:0]  byteAddr;
	logic [2:0]  bitPos;
	logic        toSfr;
	logic        allPages;
	logic [7:0]  effPage;
	logic [7:0]  oldByte;
	logic [7:0]  newByte;
	logic        selStack;
	logic        selCtrl;
	logic        selCur;
	logic        selNext;
	logic        selLast;
	logic        selStatus;
	logic        internalSfr;
	logic [7:0]  intSfrData;

	// Bank register address and the byte/bit target of the access.
	always_comb begin
		bankRegIdx = {program_status_word[BANK_HI_BIT], program_status_word[BANK_LO_BIT],
			2'b00, acc.regSel};
		bitPos = acc.addr[2:0];
		if (acc.indirect) begin
			byteAddr = ram[bankRegIdx];
		end else if (acc.bitOp && !acc.addr[7]) begin
			byteAddr = BIT_AREA_BASE + {4'h0, acc.addr[6:3]};
		end else if (acc.bitOp) begin
			byteAddr = {acc.addr[7:3], 3'b000};
		end else begin
			byteAddr = acc.addr;
		end
		toSfr = !acc.indirect && (byteAddr > LOWER_TOP);
	end

	// Register space selects; all-pages registers ignore the page value.
	always_comb begin
		allPages = (byteAddr == 8'h80) || (byteAddr == 8'h90) || (byteAddr == 8'hA0)
			|| (byteAddr == 8'hB0) || (byteAddr == ADDR_PAGE_CUR)
			|| (byteAddr == ADDR_PAGE_NEXT) || (byteAddr == ADDR_PAGE_LAST)
			|| (byteAddr == ADDR_STATUS);
		effPage = allPages ? PAGE_RST : current_page_select;
		selCtrl = toSfr && byteAddr == ADDR_PAGE_CTRL && current_page_select == PAGE_CTRL_PAGE;
		selStack = toSfr && byteAddr == ADDR_STACK_TOP && !selCtrl;
		selCur = toSfr && byteAddr == ADDR_PAGE_CUR;
		selNext = toSfr && byteAddr == ADDR_PAGE_NEXT;
		selLast = toSfr && byteAddr == ADDR_PAGE_LAST;
		selStatus = toSfr && byteAddr == ADDR_STATUS;
		internalSfr = selCtrl || selStack || selCur || selNext || selLast || selStatus;
		intSfrData = selCtrl ? {7'h00, auto_page_enable} :
			selStack ? stack_top_pointer :
			selCur ? current_page_select :
			selNext ? page_stack_second :
			selLast ? page_stack_bottom : program_status_word;
	end

	// Old byte at the target and the byte after a bit or byte write.
	always_comb begin
		oldByte = internalSfr ? intSfrData : ram[byteAddr];
		newByte = oldByte;
		if (acc.bitOp) begin
			newByte[bitPos] = acc.bitVal;
		end else begin
			newByte = acc.wdata;
		end
	end

	logic accGo;
	logic wrRam;
	logic wrSfr;
	assign accGo = ce && acc.valid && stk.op == STK_NONE;
	assign wrRam = accGo && acc.write && !toSfr;
	assign wrSfr = accGo && acc.write && internalSfr;

	////////////////////////////////////////////////////////////////////////
	// RAM storage; stack traffic uses full 8-bit addresses.
	logic [7:0] spPlus1;
	logic [7:0] spPlus2;
	logic [7:0] spMinus1;
	assign spPlus1 = stack_top_pointer + 8'h01;
	assign spPlus2 = stack_top_pointer + 8'h02;
	assign spMinus1 = stack_top_pointer - 8'h01;

	// Stack writes land anywhere in the 256 bytes, else the data access writes.
	always_ff @(posedge ref_clk) begin
		if (ce) begin
			if (stk.op == STK_PUSH) begin
				ram[spPlus1] <= stk.data[7:0];
			end else if (stk.op == STK_CALL) begin
				ram[spPlus1] <= stk.data[7:0];
				ram[spPlus2] <= stk.data[15:8];
			end else if (wrRam) begin
				ram[byteAddr] <= newByte;
			end
		end
	end

	// Stack pointer: reset value, stack moves, direct writes.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stack_top_pointer <= STACK_TOP_RST;
		end else if (ce) begin
			case (stk.op)
				STK_PUSH, STK_INC: stack_top_pointer <= spPlus1;
				STK_CALL: stack_top_pointer <= spPlus2;
				STK_POP, STK_DEC: stack_top_pointer <= spMinus1;
				STK_RET: stack_top_pointer <= stack_top_pointer - 8'h02;
				default: if (wrSfr && selStack) stack_top_pointer <= newByte;
			endcase
		end
	end

	// Status word holds the bank select bits.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			program_status_word <= STATUS_RST;
		end else if (ce && wrSfr && selStatus) begin
			program_status_word <= newByte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Page stack; interrupt events win over a software write in the same cycle.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			current_page_select <= PAGE_RST;
			page_stack_second <= PAGE_RST;
			page_stack_bottom <= PAGE_RST;
		end else if (ce) begin
			if (intEntry && auto_page_enable) begin
				page_stack_bottom <= page_stack_second;
				page_stack_second <= current_page_select;
				current_page_select <= intPage;
			end else if (intReturn && auto_page_enable) begin
				current_page_select <= page_stack_second;
				page_stack_second <= page_stack_bottom;
				page_stack_bottom <= PAGE_EMPTY;
			end else if (wrSfr) begin
				if (selCur) current_page_select <= newByte;
				if (selNext) page_stack_second <= newByte;
				if (selLast) page_stack_bottom <= newByte;
			end
		end
	end

	// Automatic paging enable, set after reset.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			auto_page_enable <= AUTO_PAGE_RST;
		end else if (ce && wrSfr && selCtrl) begin
			auto_page_enable <= newByte[AUTO_PAGE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stack record shift register with depth tracking and sticky flags.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			record <= '0;
			recordDepth <= '0;
			recordOverflow <= 1'b0;
			recordUnderflow <= 1'b0;
		end else if (ce) begin
			case (stk.op)
				STK_PUSH, STK_INC: begin
					record <= {record[RECORD_BITS-2:0], 1'b0};
					if (recordDepth == 6'(RECORD_BITS)) recordOverflow <= 1'b1;
					else recordDepth <= recordDepth + 6'd1;
				end
				STK_CALL: begin
					record <= {record[RECORD_BITS-3:0], 2'b11};
					if (recordDepth > 6'(RECORD_BITS - 2)) recordOverflow <= 1'b1;
					else recordDepth <= recordDepth + 6'd2;
				end
				STK_POP, STK_DEC: begin
					record <= {1'b0, record[RECORD_BITS-1:1]};
					if (recordDepth == 6'd0) recordUnderflow <= 1'b1;
					else recordDepth <= recordDepth - 6'd1;
				end
				STK_RET: begin
					record <= {2'b00, record[RECORD_BITS-1:2]};
					if (recordDepth < 6'd2) recordUnderflow <= 1'b1;
					else recordDepth <= recordDepth - 6'd2;
				end
				default: begin
					if (recordClear) begin
						recordOverflow <= 1'b0;
						recordUnderflow <= 1'b0;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outside register space requests; answer comes back next cycle.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sfrOut <= '0;
			extPending <= 1'b0;
			extBitOp <= 1'b0;
			extBitPos <= 3'd0;
		end else if (ce) begin
			sfrOut.req <= accGo && toSfr && !internalSfr;
			sfrOut.write <= acc.write;
			sfrOut.addr <= byteAddr;
			sfrOut.page <= effPage;
			sfrOut.wdata <= acc.bitOp ? {8{acc.bitVal}} : acc.wdata;
			sfrOut.bitMask <= acc.bitOp ? 8'(1 << bitPos) : 8'hFF;
			extPending <= accGo && toSfr && !internalSfr && !acc.write;
			extBitOp <= acc.bitOp;
			extBitPos <= bitPos;
		end
	end

	// Read answers for RAM, internal registers and the outside space.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdData <= 8'h00;
			rdValid <= 1'b0;
		end else if (ce) begin
			rdValid <= 1'b0;
			if (extPending) begin
				rdValid <= 1'b1;
				rdData <= extBitOp ? {7'h00, sfrRdData[extBitPos]} : sfrRdData;
			end else if (accGo && !acc.write && !(toSfr && !internalSfr)) begin
				rdValid <= 1'b1;
				rdData <= acc.bitOp ? {7'h00, oldByte[bitPos]} : oldByte;
			end
		end
	end

	// Pop and return data from the top of the stack.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stkRdData <= 16'h0000;
			stkRdValid <= 1'b0;
		end else if (ce) begin
			stkRdValid <= stk.op == STK_POP || stk.op == STK_RET;
			if (stk.op == STK_POP) stkRdData <= {8'h00, ram[stack_top_pointer]};
			if (stk.op == STK_RET) stkRdData <= {ram[stack_top_pointer], ram[spMinus1]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.
	stack_reset_a: assert property (@(posedge ref_clk)
		$fell(rst) |-> stack_top_pointer == 8'h07 && auto_page_enable)
		else $error("Stack pointer or paging enable wrong after reset.");
	push_step_a: assert property (@(posedge ref_clk) disable iff (rst)
		ce && stk.op == STK_PUSH |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
		else $error("Push did not advance the stack pointer by one.");
	call_step_a: assert property (@(posedge ref_clk) disable iff (rst)
		ce && stk.op == STK_CALL |=> stack_top_pointer == $past(stack_top_pointer) + 8'h02)
		else $error("Call did not advance the stack pointer by two.");
	entry_push_a: assert property (@(posedge ref_clk) disable iff (rst)
		ce && intEntry && auto_page_enable |=> current_page_select == $past(intPage)
		&& page_stack_second == $past(current_page_select)
		&& page_stack_bottom == $past(page_stack_second))
		else $error("Interrupt entry did not push the page stack.");
	return_pop_a: assert property (@(posedge ref_clk) disable iff (rst)
		ce && !intEntry && intReturn && auto_page_enable
		|=> current_page_select == $past(page_stack_second) && page_stack_bottom == 8'h00)
		else $error("Interrupt return did not pop the page stack.");
	auto_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		ce && (intEntry || intReturn) && !auto_page_enable && !wrSfr
		|=> $stable(current_page_select) && $stable(page_stack_second))
		else $error("Page stack moved while automatic paging was off.");
	record_over_a: assert property (@(posedge ref_clk) disable iff (rst)
		ce && (stk.op == STK_PUSH || stk.op == STK_INC) && recordDepth == 6'd32 |=> recordOverflow)
		else $error("Record overflow not flagged.");
	sfr_route_a: assert property (@(posedge ref_clk) disable iff (rst)
		accGo && !acc.indirect && !acc.bitOp && acc.addr > 8'h7F && !internalSfr
		|=> sfrOut.req && sfrOut.addr == $past(acc.addr) ##1 !sfrOut.req || $past(accGo))
		else $error("Direct high access did not reach the register space.");
	all_pages_a: assert property (@(posedge ref_clk) disable iff (rst)
		sfrOut.req && sfrOut.addr == 8'h90 |-> sfrOut.page == 8'h00)
		else $error("All-pages register decoded with a page.");
endmodule : data_memory_sfr_paging
`default_nettype wire

// File: verification/sfr_space_model.sv
// Model of the outside register space that answers forwarded register accesses.
`timescale 1ns/100ps
`default_nettype none
module sfr_space_model
	import dmem_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire dmem_pkg::sfrBus_t sfrOut,
	output logic [7:0]             sfrRdData
);
	import dmem_pkg::*;
	logic [7:0] idleNoise = 8'h5A;
	// Idle data flips every cycle, so a stale sample never passes for an answer.
	always_ff @(posedge ref_clk) begin
		idleNoise <= ~idleNoise;
	end
	// The answer mixes address and page, so a wrong page shows in the read data.
	always_comb begin
		sfrRdData = sfrOut.req ? (sfrOut.addr ^ sfrOut.page ^ 8'h3C) : idleNoise;
	end
endmodule : sfr_space_model
`default_nettype wire

// File: verification/tb_data_memory_sfr_paging.sv
// Self-checking bench for the data memory and register page decoder.
`timescale 1ns/100ps
`default_nettype none
module tb_data_memory_sfr_paging;
	import dmem_pkg::*;
	localparam logic [3:0] RD = 4'h0, WR = 4'h8, IRD = 4'h4, IWR = 4'hC, BRD = 4'h2, BWR = 4'hA;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	accReq_t     acc = '0;
	stackReq_t   stk = '0;
	logic        intEntry = 1'b0;
	logic        intReturn = 1'b0;
	logic        recordClear = 1'b0;
	logic [7:0]  intPage = 8'h00;
	logic [7:0]  sfrRdData, rdData, program_status_word, q;
	sfrBus_t     sfrOut, seen;
	logic [15:0] stkRdData, sq;
	logic        rdValid, stkRdValid, recordOverflow, recordUnderflow;
	int          num_errors = 0;
	int          compares = 0;
	////////////////////////////////////////////////////////////////////////////////
	// Clock, design and outside register space.
	always #2.5 ref_clk = ~ref_clk;
	data_memory_sfr_paging u_data_memory_sfr_paging (.ref_clk(ref_clk), .rst(rst), .ce(ce),
		.acc(acc), .stk(stk), .intEntry(intEntry), .intPage(intPage), .intReturn(intReturn),
		.sfrRdData(sfrRdData), .recordClear(recordClear), .sfrOut(sfrOut), .rdData(rdData),
		.rdValid(rdValid), .stkRdData(stkRdData), .stkRdValid(stkRdValid),
		.recordOverflow(recordOverflow), .recordUnderflow(recordUnderflow),
		.program_status_word(program_status_word));
	sfr_space_model u_sfr_space_model (.ref_clk(ref_clk), .sfrOut(sfrOut), .sfrRdData(sfrRdData));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seenVal, input logic [15:0] expVal);
		compares++;
		if (seenVal !== expVal) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seenVal, expVal);
		end
	endtask : check
	// One access, then four edges in which its answer and any outside request are caught.
	task automatic access(input logic [3:0] m, input logic [7:0] a, input logic [7:0] d,
		input logic v);
		q = 'x;
		seen = '0;
		@(posedge ref_clk);
		acc <= {1'b1, m, a, d, v};
		@(posedge ref_clk);
		acc.valid <= 1'b0;
		repeat (4) begin
			#1;
			if (rdValid === 1'b1) q = rdData;
			if (sfrOut.req === 1'b1) seen = sfrOut;
			@(posedge ref_clk);
		end
	endtask : access
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		access(WR, a, d, 1'b0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		access(RD, a, 8'h00, 1'b0);
		check({8'h00, q}, {8'h00, e});
	endtask : rd
	// One stack operation; a popped value is caught in the two edges after it.
	task automatic stack(input stackOp_t op, input logic [15:0] d);
		sq = 'x;
		@(posedge ref_clk);
		stk <= {op, d};
		@(posedge ref_clk);
		stk.op <= STK_NONE;
		repeat (2) begin
			#1;
			if (stkRdValid === 1'b1) sq = stkRdData;
			@(posedge ref_clk);
		end
	endtask : stack
	task automatic irq(input logic entry, input logic [7:0] p);
		@(posedge ref_clk);
		intEntry <= entry;
		intReturn <= !entry;
		intPage <= p;
		@(posedge ref_clk);
		intEntry <= 1'b0;
		intReturn <= 1'b0;
	endtask : irq
	task automatic pages(input logic [7:0] c, input logic [7:0] n, input logic [7:0] l);
		rd(ADDR_PAGE_CUR, c);
		rd(ADDR_PAGE_NEXT, n);
		rd(ADDR_PAGE_LAST, l);
	endtask : pages
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_reset();
		rd(8'h81, 8'h07);
		check({8'h00, program_status_word}, 16'h0000);
		pages(8'h00, 8'h00, 8'h00);
		wr(ADDR_PAGE_CUR, 8'h0F);
		rd(8'h81, 8'h01);
		wr(ADDR_PAGE_CUR, 8'h00);
	endtask : test_reset
	task automatic test_ram();
		wr(8'h30, 8'hA5);
		wr(8'h00, 8'h30);
		access(IRD, 8'h00, 8'h00, 1'b0);
		check({8'h00, q}, 16'h00A5);
		wr(8'h01, 8'h90);
		access(IWR | 4'h1, 8'h00, 8'h5A, 1'b0);
		access(IRD | 4'h1, 8'h00, 8'h00, 1'b0);
		check({8'h00, q}, 16'h005A);
		wr(8'hD0, 8'h18);
		check({8'h00, program_status_word}, 16'h0018);
		wr(8'h18, 8'h31);
		wr(8'h31, 8'h77);
		access(IRD, 8'h00, 8'h00, 1'b0);
		check({8'h00, q}, 16'h0077);
		wr(8'hD0, 8'h00);
		access(IRD, 8'h00, 8'h00, 1'b0);
		check({8'h00, q}, 16'h00A5);
	endtask : test_ram
	task automatic test_bits();
		wr(8'h22, 8'h00);
		wr(8'h2F, 8'h00);
		access(BWR, 8'h13, 8'h00, 1'b1);
		access(BWR, 8'h7F, 8'h00, 1'b1);
		rd(8'h22, 8'h08);
		rd(8'h2F, 8'h80);
		access(BRD, 8'h13, 8'h00, 1'b0);
		check({15'h0000, q[0]}, 16'h0001);
	endtask : test_bits
	// Outside accesses touch only addresses that the model occupies.
	task automatic test_outside();
		wr(ADDR_PAGE_CUR, 8'h02);
		rd(8'hC8, 8'hC8 ^ 8'h02 ^ 8'h3C);
		check({seen.addr, seen.page}, 16'hC802);
		check({seen.bitMask, 7'h00, seen.write}, 16'hFF00);
		rd(8'h90, 8'h90 ^ 8'h3C);
		check({seen.addr, seen.page}, 16'h9000);
		access(BWR, 8'hCB, 8'h00, 1'b1);
		check({seen.addr, seen.bitMask}, 16'hC808);
		check({seen.wdata, 7'h00, seen.write}, 16'hFF01);
		rd(ADDR_PAGE_CUR, 8'h02);
		check({15'h0000, seen.req}, 16'h0000);
		wr(ADDR_PAGE_CUR, 8'h00);
	endtask : test_outside
	task automatic test_stack();
		stack(STK_PUSH, 16'h0011);
		rd(8'h08, 8'h11);
		rd(8'h81, 8'h08);
		stack(STK_POP, 16'h0000);
		check(sq, 16'h0011);
		stack(STK_CALL, 16'h3456);
		rd(8'h08, 8'h56);
		rd(8'h09, 8'h34);
		stack(STK_RET, 16'h0000);
		check(sq, 16'h3456);
		rd(8'h81, 8'h07);
		wr(8'h81, 8'hFF);
		stack(STK_PUSH, 16'h0066);
		rd(8'h00, 8'h66);
		rd(8'h81, 8'h00);
		stack(STK_POP, 16'h0000);
		check(sq, 16'h0066);
		rd(8'h81, 8'hFF);
	endtask : test_stack
	task automatic test_record();
		repeat (RECORD_BITS) stack(STK_INC, 16'h0000);
		check({15'h0000, recordOverflow}, 16'h0000);
		stack(STK_INC, 16'h0000);
		check({15'h0000, recordOverflow}, 16'h0001);
		@(posedge ref_clk);
		recordClear <= 1'b1;
		@(posedge ref_clk);
		recordClear <= 1'b0;
		repeat (RECORD_BITS) stack(STK_DEC, 16'h0000);
		check({14'h0000, recordOverflow, recordUnderflow}, 16'h0000);
		stack(STK_DEC, 16'h0000);
		check({15'h0000, recordUnderflow}, 16'h0001);
	endtask : test_record
	// Clock enable low: a push and an interrupt entry must leave no trace.
	task automatic test_freeze();
		@(posedge ref_clk);
		ce <= 1'b0;
		stack(STK_PUSH, 16'h00AA);
		irq(1'b1, 8'h02);
		@(posedge ref_clk);
		ce <= 1'b1;
		rd(8'h81, 8'hFF);
		pages(8'h00, 8'h00, 8'h00);
	endtask : test_freeze
	task automatic test_pages();
		wr(ADDR_PAGE_CUR, 8'h0F);
		irq(1'b1, 8'h02);
		pages(8'h02, 8'h0F, 8'h00);
		irq(1'b1, 8'h00);
		pages(8'h00, 8'h02, 8'h0F);
		irq(1'b0, 8'h00);
		pages(8'h02, 8'h0F, 8'h00);
		irq(1'b0, 8'h00);
		pages(8'h0F, 8'h00, 8'h00);
		wr(ADDR_PAGE_NEXT, 8'h03);
		rd(ADDR_PAGE_CUR, 8'h0F);
		irq(1'b0, 8'h00);
		pages(8'h03, 8'h00, 8'h00);
		wr(ADDR_PAGE_CUR, 8'h0F);
		wr(8'h81, 8'h00);
		irq(1'b1, 8'h01);
		pages(8'h0F, 8'h00, 8'h00);
		wr(8'h81, 8'h01);
	endtask : test_pages
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict
	// Main sequence after eight cycles of reset.
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		test_reset();
		test_ram();
		test_bits();
		test_outside();
		test_stack();
		test_record();
		test_freeze();
		test_pages();
		print_verdict();
	end
	// Watchdog: the whole sequence needs well under two thousand cycles.
	initial begin
		repeat (6000) @(posedge ref_clk);
		num_errors++;
		print_verdict();
	end
endmodule : tb_data_memory_sfr_paging
`default_nettype wire
